/* hdl/mem_cmd_device.sv */
/*
 memory device end: command capture after chip-select latency, parity flag pulse,
 power-save command path gating, link check output.
 assumes the controller keeps its own timing; all link inputs are on clk_sys.
*/
// What this block and the controller do
// - parity flag low 80..192 cycles per grade
// - controller sends only idle within window
// - capture command after cs latency 5/6
// - gear-down capture latency 6 or 8
// - disable command path after entry delays
// - controller keeps clock valid after entry
// - controller waits exit time, unlocked commands
// - controller waits exit plus lock time
// - controller holds select high after enable
// - test enable 200 ns before select
// - link check outputs valid within 200 ns
// - flag asserted within parity latency plus 6ns
`timescale 1ns/1ps
`default_nettype none
module mem_cmd_device
   import cmd_timing_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // strap settings
   input wire logic [1:0] grade,
   input wire logic latency_en,
   input wire logic gear_down,
   input wire logic persistent_parity,
   // link
   cmd_link_if.dev link,
   // user side: captured commands
   output logic cmd_valid,
   output logic [2:0] cmd_out,
   output logic [ADDR_W-1:0] addr_out,
   output logic power_save_active,
   output logic parity_blocked
);
   typedef enum {DEV_RUN, DEV_PS_WAIT, DEV_PS} dev_state_t;
   dev_state_t state_r, state_nxt;
   logic [3:0] lat_cnt_r;
   logic lat_busy_r;
   logic [7:0] pulse_cnt_r;
   logic [7:0] ps_cnt_r;
   logic [3:0] par_cnt_r;
   logic par_pend_r;
   logic flag_n_r;
   logic [ADDR_W-1:0] test_r;
   logic cke_q_r;
   logic ps_active_r;
   logic cmd_valid_r;
   logic [2:0] cmd_r;
   logic [ADDR_W-1:0] addr_r;
   logic blocked_r;

   wire logic [3:0] lat_target = cs_latency(grade, gear_down);
   wire logic [3:0] par_lat = (grade == GRADE_2666) ? PAR_LAT_2666 : PAR_LAT_HI;
   wire logic path_on = (state_r != DEV_PS) && !link.test_enable_pin;
   wire logic cs_hit = path_on && !link.chip_select_low_n;
   wire logic capture_now = latency_en ? (lat_busy_r && lat_cnt_r == lat_target - 4'h1) : cs_hit;
   wire logic par_bad = capture_now && ((^{link.cmd, link.addr}) != link.cmd_parity);
   wire logic take = capture_now && !par_bad && !blocked_r;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         DEV_RUN: if (take && link.cmd == CMD_MRS_PS) state_nxt = DEV_PS_WAIT;
         DEV_PS_WAIT: if (ps_cnt_r == PS_ENTRY_CYC - 8'h01) state_nxt = DEV_PS;
         // exit needs a rising enable: the level is still high just after entry
         DEV_PS: if (link.clk_enable && !cke_q_r && link.chip_select_low_n) state_nxt = DEV_RUN;
         default: state_nxt = DEV_RUN;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_r <= DEV_RUN;
         ps_cnt_r <= 8'h00;
         cke_q_r <= 1'b1;
         ps_active_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         ps_cnt_r <= (state_r == DEV_PS_WAIT) ? ps_cnt_r + 8'h01 : 8'h00;
         cke_q_r <= link.clk_enable;
         ps_active_r <= (state_nxt == DEV_PS);
      end
   end

   // latency counter from chip-select to capture
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         lat_busy_r <= 1'b0;
         lat_cnt_r <= 4'h0;
      end
      else if (lat_busy_r)
      begin
         lat_cnt_r <= lat_cnt_r + 4'h1;
         if (lat_cnt_r == lat_target - 4'h1)
            lat_busy_r <= 1'b0;
      end
      else if (latency_en && cs_hit)
      begin
         lat_busy_r <= 1'b1;
         lat_cnt_r <= 4'h1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         cmd_valid_r <= 1'b0;
         cmd_r <= CMD_NOP;
         addr_r <= '0;
      end
      else
      begin
         cmd_valid_r <= take;
         if (take)
         begin
            cmd_r <= link.cmd;
            addr_r <= link.addr;
         end
      end
   end

   // parity error: delay flag by parity latency, then hold min width
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         par_pend_r <= 1'b0;
         par_cnt_r <= 4'h0;
         pulse_cnt_r <= 8'h00;
         flag_n_r <= 1'b1;
         blocked_r <= 1'b0;
      end
      else
      begin
         if (par_bad && flag_n_r && !par_pend_r)
         begin
            par_pend_r <= 1'b1;
            par_cnt_r <= 4'h1;
         end
         else if (par_pend_r)
         begin
            par_cnt_r <= par_cnt_r + 4'h1;
            if (par_cnt_r >= par_lat - 4'(PAR_EXTRA_CYC))
            begin
               par_pend_r <= 1'b0;
               flag_n_r <= 1'b0;
               pulse_cnt_r <= 8'h01;
               blocked_r <= persistent_parity;
            end
         end
         else if (!flag_n_r)
         begin
            pulse_cnt_r <= pulse_cnt_r + 8'h01;
            if (pulse_cnt_r == pulse_min(grade))
            begin
               flag_n_r <= 1'b1;
               blocked_r <= 1'b0;
            end
         end
      end
   end

   // link check: inverted address one cycle after select, well inside 200 ns
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         test_r <= '0;
      else if (link.test_enable_pin && !link.chip_select_low_n)
         test_r <= ~link.addr;
      else
         test_r <= '0;
   end

   assign link.parity_error_flag_n = flag_n_r;
   assign link.test_out = test_r;
   assign cmd_valid = cmd_valid_r;
   assign cmd_out = cmd_r;
   assign addr_out = addr_r;
   assign power_save_active = ps_active_r;
   assign parity_blocked = blocked_r;
endmodule : mem_cmd_device
`default_nettype wire

/* hdl/cmd_timing_pkg.sv */
/*
 package of cycle counts and timing constants for the command-link timing pair.
 assumes a single 25 MHz clk_sys shared by both ends.
*/
package cmd_timing_pkg;
   localparam int CLK_PERIOD_NS = 40;
   // speed grades
   localparam logic [1:0] GRADE_2666 = 2'h0;
   localparam logic [1:0] GRADE_2933 = 2'h1;
   localparam logic [1:0] GRADE_3200 = 2'h2;
   // parity flag pulse width, min and max, per grade (cycles)
   localparam logic [7:0] PW_MIN_2666 = 8'h50;
   localparam logic [7:0] PW_MIN_2933 = 8'h58;
   localparam logic [7:0] PW_MIN_3200 = 8'h60;
   localparam logic [7:0] PW_MAX_2666 = 8'hA0;
   localparam logic [7:0] PW_MAX_2933 = 8'hB0;
   localparam logic [7:0] PW_MAX_3200 = 8'hC0;
   // response window to idle-only commands (cycles)
   localparam logic [7:0] RSP_2666 = 8'h47;
   localparam logic [7:0] RSP_2933 = 8'h4E;
   localparam logic [7:0] RSP_3200 = 8'h55;
   // chip-select to capture latency, normal and gear-down
   localparam logic [3:0] CAL_2666 = 4'h5;
   localparam logic [3:0] CAL_HI = 4'h6;
   localparam logic [3:0] CALG_2666 = 4'h6;
   localparam logic [3:0] CALG_HI = 4'h8;
   // parity latency and flag delay
   localparam logic [3:0] PAR_LAT_2666 = 4'h5;
   localparam logic [3:0] PAR_LAT_HI = 4'h6;
   localparam int PAR_EXTRA_NS = 6;
   localparam int PAR_EXTRA_CYC = PAR_EXTRA_NS / CLK_PERIOD_NS;
   // mode-register and power-save delays (cycles, plain defaults)
   localparam logic [7:0] MODE_UPDATE_CYC = 8'h18;
   localparam logic [7:0] CMD_DISABLE_CYC = 8'h04;
   localparam logic [7:0] PS_ENTRY_CYC = MODE_UPDATE_CYC + CMD_DISABLE_CYC;
   localparam logic [11:0] SR_EXIT_CYC = 12'h120;
   localparam logic [11:0] SR_EXIT_LOCKED_CYC = 12'h300;
   localparam logic [11:0] PS_EXIT_LOCKED_CYC = SR_EXIT_CYC + SR_EXIT_LOCKED_CYC;
   localparam logic [7:0] PD_EXIT_CYC = 8'h06;
   // link check timing
   localparam int LC_ENTRY_NS = 200;
   localparam int LC_OUT_NS = 200;
   localparam int LC_CLK_NS = 10;
   localparam logic [7:0] LC_ENTRY_CYC = 8'((LC_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] LC_OUT_CYC = 8'(LC_OUT_NS / CLK_PERIOD_NS);
   localparam logic [7:0] LC_CLK_CYC = 8'((LC_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // command codes on the link
   localparam logic [2:0] CMD_NOP = 3'h0;
   localparam logic [2:0] CMD_MRS_PS = 3'h1;
   localparam logic [2:0] CMD_PLAIN = 3'h2;
   localparam logic [2:0] CMD_LOCKED = 3'h3;
   localparam int ADDR_W = 8;

   function automatic logic [3:0] cs_latency(input logic [1:0] g, input logic gear);
      if (gear)
         return (g == GRADE_2666) ? CALG_2666 : CALG_HI;
      return (g == GRADE_2666) ? CAL_2666 : CAL_HI;
   endfunction : cs_latency

   function automatic logic [7:0] pulse_min(input logic [1:0] g);
      return (g == GRADE_2666) ? PW_MIN_2666 : (g == GRADE_2933) ? PW_MIN_2933 : PW_MIN_3200;
   endfunction : pulse_min

   function automatic logic [7:0] rsp_window(input logic [1:0] g);
      return (g == GRADE_2666) ? RSP_2666 : (g == GRADE_2933) ? RSP_2933 : RSP_3200;
   endfunction : rsp_window
endpackage : cmd_timing_pkg

/* hdl/cmd_link_if.sv */
/*
 interface joining memory controller end and memory device end.
 assumes both ends run on the same clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface cmd_link_if;
   import cmd_timing_pkg::*;
   logic chip_select_low_n;
   logic clk_enable;
   logic test_enable_pin;
   logic [2:0] cmd;
   logic [ADDR_W-1:0] addr;
   logic cmd_parity;
   logic parity_error_flag_n;
   logic [ADDR_W-1:0] test_out;
   modport ctrl (output chip_select_low_n, output clk_enable, output test_enable_pin, output cmd, output addr,
      output cmd_parity, input parity_error_flag_n, input test_out);
   modport dev (input chip_select_low_n, input clk_enable, input test_enable_pin, input cmd, input addr,
      input cmd_parity, output parity_error_flag_n, output test_out);
endinterface : cmd_link_if
`default_nettype wire

/* hdl/mem_cmd_controller.sv */
/*
 memory controller end: issues commands with chip-select latency, respects parity
 window, power-save entry and exit waits, link check entry.
 assumes the device end on the same clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_cmd_controller
   import cmd_timing_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // settings
   input wire logic [1:0] grade,
   input wire logic latency_en,
   input wire logic gear_down,
   // user request
   input wire logic req_valid,
   input wire logic [2:0] req_cmd,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic ps_exit_req,
   input wire logic test_req,
   output logic req_ready,
   output logic parity_seen,
   // link
   cmd_link_if.ctrl link
);
   typedef enum {C_IDLE, C_HOLD, C_PS_ENTRY, C_PS, C_PS_EXIT, C_TEST} ctrl_state_t;
   ctrl_state_t state_r;
   logic [11:0] cnt_r;
   logic [11:0] exit_cnt_r;
   logic cs_n_r, cke_r, test_en_r, par_r;
   logic [2:0] cmd_r;
   logic [ADDR_W-1:0] addr_r;
   logic flag_q1_r, flag_q2_r;
   logic seen_r;

   wire logic [3:0] hold_len = latency_en ? cs_latency(grade, gear_down) : 4'h1;
   wire logic flag_low = !flag_q2_r;
   wire logic can_issue = (state_r == C_IDLE) && !flag_low && !seen_r;
   wire logic plain_ok = exit_cnt_r >= SR_EXIT_CYC;
   wire logic locked_ok = exit_cnt_r >= PS_EXIT_LOCKED_CYC;
   wire logic gate_ok = (req_cmd == CMD_LOCKED) ? locked_ok : (req_cmd == CMD_PLAIN) ? plain_ok : 1'b1;
   wire logic start = can_issue && req_valid && gate_ok;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         flag_q1_r <= 1'b1;
         flag_q2_r <= 1'b1;
         seen_r <= 1'b0;
      end
      else
      begin
         flag_q1_r <= link.parity_error_flag_n;
         flag_q2_r <= flag_q1_r;
         seen_r <= flag_low;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_r <= C_IDLE;
         cnt_r <= 12'h000;
         exit_cnt_r <= PS_EXIT_LOCKED_CYC;
         cs_n_r <= 1'b1;
         cke_r <= 1'b1;
         test_en_r <= 1'b0;
         cmd_r <= CMD_NOP;
         addr_r <= '0;
         par_r <= 1'b0;
      end
      else
      begin
         if (exit_cnt_r < PS_EXIT_LOCKED_CYC)
            exit_cnt_r <= exit_cnt_r + 12'h001;
         case (state_r)
            C_IDLE:
            begin
               cs_n_r <= 1'b1;
               cmd_r <= CMD_NOP;
               if (test_req)
               begin
                  test_en_r <= 1'b1;
                  cnt_r <= 12'h000;
                  state_r <= C_TEST;
               end
               else if (start)
               begin
                  cs_n_r <= 1'b0;
                  cmd_r <= req_cmd;
                  addr_r <= req_addr;
                  par_r <= ^{req_cmd, req_addr};
                  cnt_r <= 12'h001;
                  state_r <= C_HOLD;
               end
            end
            C_HOLD:
            begin
               cs_n_r <= 1'b1;
               cnt_r <= cnt_r + 12'h001;
               if (cnt_r >= {8'h00, hold_len})
               begin
                  cnt_r <= 12'h000;
                  state_r <= (cmd_r == CMD_MRS_PS) ? C_PS_ENTRY : C_IDLE;
                  cmd_r <= CMD_NOP;
               end
            end
            C_PS_ENTRY:
            begin
               cnt_r <= cnt_r + 12'h001;
               if (cnt_r >= {4'h0, PS_ENTRY_CYC})
                  state_r <= C_PS;
            end
            C_PS:
            begin
               cnt_r <= 12'h000;
               // leave only after the enable has really dropped once
               if (ps_exit_req && !cke_r)
               begin
                  cke_r <= 1'b1;
                  state_r <= C_PS_EXIT;
               end
               else
                  cke_r <= 1'b0;
            end
            C_PS_EXIT:
            begin
               cs_n_r <= 1'b1;
               cnt_r <= cnt_r + 12'h001;
               if (cnt_r >= {4'h0, PD_EXIT_CYC})
               begin
                  exit_cnt_r <= 12'h000;
                  state_r <= C_IDLE;
               end
            end
            C_TEST:
            begin
               cnt_r <= cnt_r + 12'h001;
               cke_r <= 1'b1;
               if (cnt_r >= {4'h0, LC_ENTRY_CYC})
                  cs_n_r <= 1'b0;
               if (!test_req)
               begin
                  test_en_r <= 1'b0;
                  cs_n_r <= 1'b1;
                  state_r <= C_IDLE;
               end
            end
            default: state_r <= C_IDLE;
         endcase
      end
   end

   assign link.chip_select_low_n = cs_n_r;
   assign link.clk_enable = cke_r;
   assign link.test_enable_pin = test_en_r;
   assign link.cmd = cmd_r;
   assign link.addr = addr_r;
   assign link.cmd_parity = par_r;
   // ready only when the exit wait for this command kind is over
   assign req_ready = can_issue && gate_ok;
   assign parity_seen = seen_r;
endmodule : mem_cmd_controller
`default_nettype wire

/* tb/cmd_link_chk.sv */
/*
 checker of the command link between controller end and device end.
 assumes it is instantiated in the bench beside the interface joining the two ends.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_link_chk
   import cmd_timing_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // link
   input wire logic chip_select_low_n,
   input wire logic clk_enable,
   input wire logic test_enable_pin,
   input wire logic [2:0] cmd,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic cmd_parity,
   input wire logic parity_error_flag_n,
   input wire logic [ADDR_W-1:0] test_out
);
   logic [11:0] exit_cnt_r;
   logic [7:0] entry_cnt_r;
   wire logic cmd_on = !chip_select_low_n;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // saturated after reset, so a fresh start counts as long settled
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         exit_cnt_r <= 12'hFFF;
      else if (!clk_enable)
         exit_cnt_r <= 12'h000;
      else if (exit_cnt_r != 12'hFFF)
         exit_cnt_r <= exit_cnt_r + 12'h001;
   end
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         entry_cnt_r <= 8'h00;
      else if (cmd_on && cmd == CMD_MRS_PS)
         entry_cnt_r <= PS_ENTRY_CYC;
      else if (entry_cnt_r != 8'h00)
         entry_cnt_r <= entry_cnt_r - 8'h01;
   end
   sequence s_cs_high_hold;
      chip_select_low_n [*6];
   endsequence
   property p_cs_one_cycle;
      $fell(chip_select_low_n) && !test_enable_pin |=> chip_select_low_n;
   endproperty
   property p_parity_even;
      cmd_on && !test_enable_pin |-> cmd_parity == ^{cmd, addr};
   endproperty
   property p_flag_idle;
      parity_error_flag_n;
   endproperty
   property p_test_entry;
      $fell(chip_select_low_n) && test_enable_pin |-> $past(test_enable_pin, 5);
   endproperty
   property p_test_out;
      test_enable_pin && cmd_on |=> test_out == ~$past(addr);
   endproperty
   property p_clk_after_test;
      $rose(test_enable_pin) |-> clk_enable;
   endproperty
   property p_entry_clock;
      entry_cnt_r != 8'h00 |-> clk_enable;
   endproperty
   property p_exit_hold;
      $rose(clk_enable) |-> s_cs_high_hold;
   endproperty
   property p_plain_wait;
      cmd_on && cmd == CMD_PLAIN |-> exit_cnt_r >= SR_EXIT_CYC;
   endproperty
   property p_locked_wait;
      cmd_on && cmd == CMD_LOCKED |-> exit_cnt_r >= PS_EXIT_LOCKED_CYC;
   endproperty
   a_cs_one_cycle: assert property (p_cs_one_cycle) else $error("select low too long");
   a_parity_even: assert property (p_parity_even) else $error("bad command parity");
   a_flag_idle: assert property (p_flag_idle) else $error("flag low without error");
   a_test_entry: assert property (p_test_entry) else $error("select too soon after test");
   a_test_out: assert property (p_test_out) else $error("test output wrong");
   a_clk_after_test: assert property (p_clk_after_test) else $error("clock enable low in test");
   a_entry_clock: assert property (p_entry_clock) else $error("clock dropped after entry");
   a_exit_hold: assert property (p_exit_hold) else $error("select low after exit");
   a_plain_wait: assert property (p_plain_wait) else $error("plain command too early");
   a_locked_wait: assert property (p_locked_wait) else $error("locked command too early");
endmodule : cmd_link_chk
`default_nettype wire

/* tb/tb.sv */
/*
 bench for the controller and device ends, joined link plus a second device driven by hand.
 assumes the package constants and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
   import cmd_timing_pkg::*;
;
   logic clk_sys, rst_n, latency_en, gear_down, req_valid, ps_exit_req, test_req;
   logic [1:0] grade;
   logic [2:0] req_cmd;
   logic [ADDR_W-1:0] req_addr;
   wire logic cmd_valid, power_save_active, parity_blocked, req_ready, parity_seen, cmd_valid_2, parity_blocked_2;
   wire logic [2:0] cmd_out;
   wire logic [ADDR_W-1:0] addr_out;
   int mismatches, checks_done, cyc, i, n, m, t0;
   logic [3:0] cfg_tab [6] = '{4'h0, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE};
   int exp_tab [6] = '{1, 5, 6, 6, 8, 8};
   cmd_link_if link();
   cmd_link_if link_2();
   mem_cmd_controller u_mem_cmd_controller (.clk_sys(clk_sys), .rst_n(rst_n), .grade(grade),
      .latency_en(latency_en), .gear_down(gear_down), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_addr(req_addr), .ps_exit_req(ps_exit_req), .test_req(test_req), .req_ready(req_ready),
      .parity_seen(parity_seen), .link(link));
   mem_cmd_device u_mem_cmd_device (.clk_sys(clk_sys), .rst_n(rst_n), .grade(grade), .latency_en(latency_en),
      .gear_down(gear_down), .persistent_parity(1'b0), .link(link), .cmd_valid(cmd_valid), .cmd_out(cmd_out),
      .addr_out(addr_out), .power_save_active(power_save_active), .parity_blocked(parity_blocked));
   mem_cmd_device u_mem_cmd_device_2 (.clk_sys(clk_sys), .rst_n(rst_n), .grade(GRADE_3200), .latency_en(1'b0),
      .gear_down(1'b0), .persistent_parity(1'b1), .link(link_2), .cmd_valid(cmd_valid_2), .cmd_out(),
      .addr_out(), .power_save_active(), .parity_blocked(parity_blocked_2));
   cmd_link_chk u_cmd_link_chk (.clk_sys(clk_sys), .rst_n(rst_n), .chip_select_low_n(link.chip_select_low_n),
      .clk_enable(link.clk_enable), .test_enable_pin(link.test_enable_pin), .cmd(link.cmd), .addr(link.addr),
      .cmd_parity(link.cmd_parity), .parity_error_flag_n(link.parity_error_flag_n), .test_out(link.test_out));

   task test_done();
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task do_reset();
      rst_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
   endtask : do_reset

   // held until the controller takes it, released at the next falling edge
   task issue(input logic [2:0] c, input logic [ADDR_W-1:0] a);
      req_valid = 1'b1;
      req_cmd = c;
      req_addr = a;
      while (req_ready !== 1'b1)
         @(negedge clk_sys);
      @(negedge clk_sys);
      req_valid = 1'b0;
   endtask : issue

   task wait_cs();
      while (link.chip_select_low_n !== 1'b0)
         @(negedge clk_sys);
   endtask : wait_cs

   // hand-driven command on the second link; bad inverts the parity bit
   task drive2(input logic [2:0] c, input logic [ADDR_W-1:0] a, input logic bad);
      link_2.chip_select_low_n = 1'b0;
      link_2.cmd = c;
      link_2.addr = a;
      link_2.cmd_parity = (^{c, a}) ^ bad;
      @(negedge clk_sys);
      link_2.chip_select_low_n = 1'b1;
      link_2.cmd = CMD_NOP;
      link_2.addr = ~a;
   endtask : drive2

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         test_done();
      end
   end

   initial
   begin
      {rst_n, latency_en, gear_down, grade, req_valid, ps_exit_req, test_req} = 8'h00;
      req_cmd = CMD_NOP;
      req_addr = 8'h00;
      {link_2.chip_select_low_n, link_2.clk_enable, link_2.test_enable_pin, link_2.cmd_parity} = 4'hC;
      link_2.cmd = CMD_NOP;
      link_2.addr = 8'h00;
      mismatches = 0;
      checks_done = 0;
      cyc = 0;
      for (i = 0; i < 6; i++)
      begin
         {latency_en, gear_down, grade} = cfg_tab[i];
         do_reset();
         issue(CMD_PLAIN, 8'(8'h50 + i));
         wait_cs();
         m = 0;
         while (cmd_valid !== 1'b1 && m < 20)
         begin
            @(negedge clk_sys);
            m++;
         end
         chk("capture latency", 16'(exp_tab[i]), 16'(m));
         chk("captured addr", 16'(8'h50 + i), 16'(addr_out));
         chk("captured cmd", 16'(CMD_PLAIN), 16'(cmd_out));
      end
      {latency_en, gear_down, grade} = 4'h0;
      do_reset();
      test_req = 1'b1;
      wait_cs();
      m = 0;
      while (link.test_out !== ~link.addr && m < 8)
      begin
         @(negedge clk_sys);
         m++;
      end
      chk("link check output", 16'h1, 16'(m <= LC_OUT_CYC));
      test_req = 1'b0;
      repeat (10) @(negedge clk_sys);
      drive2(CMD_PLAIN, 8'h3C, 1'b1);
      n = 1;
      while (link_2.parity_error_flag_n !== 1'b0 && n < 20)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk("flag delay", 16'h1, 16'(n <= PAR_LAT_HI + 1));
      t0 = cyc;
      repeat (9) @(negedge clk_sys);
      chk("parity blocked", 16'h1, 16'(parity_blocked_2));
      drive2(CMD_PLAIN, 8'h3D, 1'b0);
      for (m = 0; m < 3; m++)
      begin
         chk("blocked capture", 16'h0, 16'(cmd_valid_2));
         @(negedge clk_sys);
      end
      m = 0;
      while (link_2.parity_error_flag_n === 1'b0 && m < 300)
      begin
         @(negedge clk_sys);
         m++;
      end
      chk("flag width", 16'h1, 16'(cyc - t0 >= PW_MIN_3200 && cyc - t0 <= PW_MAX_3200));
      drive2(CMD_PLAIN, 8'h3E, 1'b0);
      chk("capture after flag", 16'h1, 16'(cmd_valid_2));
      chk("flag idle", 16'h1, 16'(link_2.parity_error_flag_n));
      issue(CMD_MRS_PS, 8'h00);
      n = 0;
      while (power_save_active !== 1'b1 && n < 60)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk("power save entry", 16'h1, 16'(n >= PS_ENTRY_CYC + 1 && n <= PS_ENTRY_CYC + 2));
      repeat (4) @(negedge clk_sys);
      chk("power save held", 16'h1, 16'(power_save_active));
      ps_exit_req = 1'b1;
      @(negedge clk_sys);
      while (link.clk_enable !== 1'b1)
         @(negedge clk_sys);
      t0 = cyc;
      ps_exit_req = 1'b0;
      issue(CMD_PLAIN, 8'h11);
      wait_cs();
      chk("plain after exit", 16'h1, 16'(cyc - t0 >= SR_EXIT_CYC));
      chk("power save left", 16'h0, 16'(power_save_active));
      issue(CMD_LOCKED, 8'h22);
      wait_cs();
      chk("locked after exit", 16'h1, 16'(cyc - t0 >= PS_EXIT_LOCKED_CYC));
      chk("parity seen idle", 16'h0, 16'(parity_seen));
      repeat (5) @(negedge clk_sys);
      test_done();
   end
endmodule : tb
`default_nettype wire
